//--- core/wdr_pkg.sv
package wdr_pkg;

   // ==========================================================================
   // clocks and times
   // ==========================================================================
   localparam int          CLK_HZ         = 50_000_000;           // system clock
   localparam int          OSC_HZ         = 128_000;              // watchdog oscillator rate
   localparam int          OSC_DIV        = CLK_HZ / OSC_HZ;      // clocks per oscillator tick
   localparam int          TOUT_MIN_MS    = 16;                   // shortest timeout, ms
   localparam int          TOUT_MAX_MS    = 8000;                 // longest timeout, ms
   localparam int          STARTUP_CYCLES = 1024;                 // start-up delay, clocks
   localparam int          DIV_W          = 12;
   localparam int          DLY_W          = 16;

   // ==========================================================================
   // timeout counter
   // ==========================================================================
   localparam int          CNT_W          = 21;
   localparam logic [20:0] TOUT_BASE      = 21'h000800;           // 2048 oscillator cycles
   localparam logic [3:0]  SEL_MAX        = 4'h9;                 // 1048576 cycles
   localparam logic [2:0]  UNLOCK_CYCLES  = 3'h4;

   // ==========================================================================
   // register map
   // ==========================================================================
   localparam int          ADDR_W         = 4;
   localparam logic [3:0]  ADDR_CAUSE     = 4'h0;
   localparam logic [3:0]  ADDR_WDCTL     = 4'h1;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       debug_port_cause_flag;
      logic       wdog_cause_flag;
      logic       brownout_cause_flag;
      logic       pin_cause_flag;
      logic       poweron_cause_flag;
   } wdr_cause_t;

   typedef struct packed {
      logic       timeout_irq_flag;
      logic       timeout_irq_enable;
      logic       sel_hi;
      logic       change_unlock;
      logic       sys_reset_enable;
      logic [2:0] sel_lo;
   } wdr_ctl_t;

   typedef struct packed {
      logic       always_on_fuse;
      logic       brownout_enable;
      logic       brownout_low;
      logic       pin_rst_n;
      logic       jtag_rst;
   } wdr_pins_t;

   localparam wdr_cause_t CAUSE_RST = wdr_cause_t'(8'h01);       // power-on flag set
   localparam wdr_ctl_t   CTL_RST   = wdr_ctl_t'(8'h00);
   localparam wdr_pins_t  PINS_RST  = wdr_pins_t'(5'h02);        // reset pin idles high

   typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_DELAY} wdr_seq_t;

   // timeout length in oscillator cycles; reserved codes act as the longest
   function automatic logic [20:0] timeout_limit(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > SEL_MAX) ? SEL_MAX : sel;
      return TOUT_BASE << s;
   endfunction : timeout_limit

endpackage : wdr_pkg

//--- core/wdr_watchdog_reset.sv
// Notes on behaviour
// - counter advances on oscillator ticks, expires
// - restart instruction clears counter before timeout
// - timeouts span 16 ms to 8 s
// - interrupt mode raises irq, no reset
// - reset mode expiry resets the system
// - combined mode: irq first, then reset
// - fuse forces reset enable 1, irq enable 0
// - select and reset-enable clear accepted only within four-cycle window
// - one-cycle reset pulse, delay after its fall
// - brown-out holds reset, delay after release
// - debug port flag bit 4, set by debug reset
// - watchdog flag bit 3, cleared POR or write
// - brown-out flag bit 2, cleared POR or write
// - pin flag bit 1, cleared POR or write
// - power-on flag bit 0, only write clears
// - watchdog stays enabled through its own reset
// - unlock bit self-clears after four cycles
// - watchdog flag forces reset enable to one
// - vector ack clears flag, and irq enable only while reset enabled
// - select 0..9 doubles from 2048 cycles
module wdr_watchdog_reset #(
   parameter int P_OSC_DIV        = wdr_pkg::OSC_DIV,
   parameter int P_STARTUP_CYCLES = wdr_pkg::STARTUP_CYCLES
) (
   input  wire logic                        I_CLK,
   input  wire logic                        I_NRST,
   input  wire logic [wdr_pkg::ADDR_W-1:0]  I_ADDR,
   input  wire logic [7:0]                  I_WDATA,
   input  wire logic                        I_WR,
   input  wire logic                        I_RD,
   output logic      [7:0]                  O_RDATA,
   input  wire logic                        I_WDR,
   input  wire logic                        I_IRQ_ACK,
   input  wire logic                        I_ALWAYS_ON_FUSE,
   input  wire logic                        I_BROWNOUT_ENABLE,
   input  wire logic                        I_BROWNOUT_LOW,
   input  wire logic                        I_PIN_RST_N,
   input  wire logic                        I_JTAG_RST,
   output logic                             O_TIMEOUT_IRQ,
   output logic                             O_WDOG_RST_PULSE,
   output logic                             O_CORE_RST
);
   import wdr_pkg::*;

   // ==========================================================================
   // pin synchronisers
   // ==========================================================================
   wdr_pins_t raw;
   wdr_pins_t s1_r, s2_r, s3_r, pin_r;
   wdr_pins_t pin_nxt;

   assign raw = '{always_on_fuse: I_ALWAYS_ON_FUSE, brownout_enable: I_BROWNOUT_ENABLE,
                  brownout_low: I_BROWNOUT_LOW, pin_rst_n: I_PIN_RST_N, jtag_rst: I_JTAG_RST};

   // a bit changes only once second and third stage agree
   always_comb begin
      pin_nxt = pin_r;
      for (int i = 0; i < $bits(wdr_pins_t); i++) begin
         if (s2_r[i] == s3_r[i]) begin
            pin_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         s1_r  <= PINS_RST;
         s2_r  <= PINS_RST;
         s3_r  <= PINS_RST;
         pin_r <= PINS_RST;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= pin_nxt;
      end
   end

   // ==========================================================================
   // state declarations and shared terms
   // ==========================================================================
   logic [DIV_W-1:0] div_r, div_nxt;
   logic             tick;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   wdr_ctl_t         ctl_r, ctl_nxt, ctl_d;
   logic [2:0]       unl_r, unl_nxt;
   wdr_cause_t       cause_r, cause_nxt, cause_d;
   logic             pulse_r, pulse_nxt;
   wdr_seq_t         seq_r, seq_nxt;
   logic [DLY_W-1:0] dly_r, dly_nxt;
   logic             core_r, core_nxt;
   logic [7:0]       rdata_r, rdata_nxt;
   logic             rst_en_eff, ie_eff, running, expire, fire, set_flag, win_open;
   logic             brownout_rst, pin_rst, hold_src;
   logic             wr_ctl, wr_cause;

   assign ctl_d    = wdr_ctl_t'(I_WDATA);
   assign cause_d  = wdr_cause_t'(I_WDATA);
   assign wr_ctl   = I_WR && (I_ADDR == ADDR_WDCTL);
   assign wr_cause = I_WR && (I_ADDR == ADDR_CAUSE);
   assign win_open = (unl_r != 3'h0);
   assign brownout_rst = pin_r.brownout_enable && pin_r.brownout_low;
   assign pin_rst  = !pin_r.pin_rst_n;

   // effective mode bits: fuse and watchdog flag override software
   assign rst_en_eff = ctl_r.sys_reset_enable || cause_r.wdog_cause_flag ||
                       pin_r.always_on_fuse;
   assign ie_eff   = ctl_r.timeout_irq_enable && !pin_r.always_on_fuse;
   assign running  = rst_en_eff || ie_eff;

   // ==========================================================================
   // oscillator tick divider
   // ==========================================================================
   always_comb begin
      tick    = (div_r == DIV_W'(P_OSC_DIV - 1));
      div_nxt = tick ? '0 : div_r + DIV_W'(1);
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // ==========================================================================
   // timeout counter
   // ==========================================================================
   // compare with >= so a shorter select expires on the next oscillator tick
   always_comb begin
      expire = tick && running && !core_r &&
               (cnt_r >= timeout_limit({ctl_r.sel_hi, ctl_r.sel_lo}) - CNT_W'(1));
      if (core_r || I_WDR || !running) begin
         cnt_nxt = '0;
      end else if (expire) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = cnt_r + CNT_W'(1);
      end else begin
         cnt_nxt = cnt_r;
      end
      set_flag = expire && ie_eff;
      fire     = expire && rst_en_eff && (!ie_eff || ctl_r.timeout_irq_flag);
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ==========================================================================
   // watchdog control register and unlock window
   // ==========================================================================
   always_comb begin
      ctl_nxt = ctl_r;
      unl_nxt = win_open ? unl_r - 3'h1 : 3'h0;
      ctl_nxt.change_unlock = 1'b0;
      if (core_r) begin
         ctl_nxt = CTL_RST;
         unl_nxt = 3'h0;
      end else begin
         if (wr_ctl) begin
            ctl_nxt.timeout_irq_enable = ctl_d.timeout_irq_enable;
            if (ctl_d.timeout_irq_flag) begin
               ctl_nxt.timeout_irq_flag = 1'b0;                                    // write one clears
            end
            if (ctl_d.change_unlock && ctl_d.sys_reset_enable) begin
               unl_nxt = UNLOCK_CYCLES;
               ctl_nxt.sys_reset_enable = 1'b1;
            end else if (win_open && !ctl_d.change_unlock) begin
               ctl_nxt.sys_reset_enable = ctl_d.sys_reset_enable;
               ctl_nxt.sel_hi           = ctl_d.sel_hi;
               ctl_nxt.sel_lo           = ctl_d.sel_lo;
               unl_nxt                  = 3'h0;
            end else begin
               ctl_nxt.sys_reset_enable = ctl_r.sys_reset_enable || ctl_d.sys_reset_enable;
            end
         end
         if (I_IRQ_ACK) begin
            ctl_nxt.timeout_irq_flag = 1'b0;
            if (rst_en_eff) begin
               ctl_nxt.timeout_irq_enable = 1'b0;
            end
         end
         if (set_flag) begin
            ctl_nxt.timeout_irq_flag = 1'b1;                                       // set wins over clear
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ctl_r <= CTL_RST;
         unl_r <= 3'h0;
      end else begin
         ctl_r <= ctl_nxt;
         unl_r <= unl_nxt;
      end
   end

   // ==========================================================================
   // reset cause flags
   // ==========================================================================
   // power-on flag is set by the asynchronous power-on reset only
   always_comb begin
      cause_nxt = cause_r;
      if (wr_cause) begin
         cause_nxt = cause_r & cause_d;
      end
      cause_nxt.rsvd = 3'h0;
      if (pin_r.jtag_rst) begin
         cause_nxt.debug_port_cause_flag = 1'b1;
      end
      if (fire) begin
         cause_nxt.wdog_cause_flag = 1'b1;
      end
      if (brownout_rst) begin
         cause_nxt.brownout_cause_flag = 1'b1;
      end
      if (pin_rst) begin
         cause_nxt.pin_cause_flag = 1'b1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cause_r <= CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // ==========================================================================
   // reset sequencer: pulse, hold, start-up delay
   // ==========================================================================
   always_comb begin
      pulse_nxt = fire;
      hold_src  = pulse_r || brownout_rst || pin_rst || pin_r.jtag_rst;
      seq_nxt   = seq_r;
      dly_nxt   = dly_r;
      case (seq_r)
         SEQ_RUN: begin
            if (hold_src) begin
               seq_nxt = SEQ_HOLD;
            end
         end
         SEQ_HOLD: begin
            if (!hold_src) begin
               seq_nxt = SEQ_DELAY;
               dly_nxt = DLY_W'(P_STARTUP_CYCLES - 1);
            end
         end
         SEQ_DELAY: begin
            if (hold_src) begin
               seq_nxt = SEQ_HOLD;
            end else if (dly_r == '0) begin
               seq_nxt = SEQ_RUN;
            end else begin
               dly_nxt = dly_r - DLY_W'(1);
            end
         end
         default: begin
            seq_nxt = SEQ_HOLD;
         end
      endcase
      core_nxt = (seq_nxt != SEQ_RUN) || hold_src;
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pulse_r <= 1'b0;
         seq_r   <= SEQ_DELAY;
         dly_r   <= DLY_W'(P_STARTUP_CYCLES - 1);
         core_r  <= 1'b1;
      end else begin
         pulse_r <= pulse_nxt;
         seq_r   <= seq_nxt;
         dly_r   <= dly_nxt;
         core_r  <= core_nxt;
      end
   end

   // ==========================================================================
   // read port
   // ==========================================================================
   always_comb begin
      rdata_nxt = 8'h00;
      if (I_RD) begin
         if (I_ADDR == ADDR_CAUSE) begin
            rdata_nxt = cause_r;
         end else if (I_ADDR == ADDR_WDCTL) begin
            rdata_nxt = {ctl_r.timeout_irq_flag, ie_eff, ctl_r.sel_hi, win_open, rst_en_eff, ctl_r.sel_lo};
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // outputs
   assign O_RDATA          = rdata_r;
   assign O_TIMEOUT_IRQ    = ctl_r.timeout_irq_flag && ie_eff;
   assign O_WDOG_RST_PULSE = pulse_r;
   assign O_CORE_RST       = core_r;

endmodule : wdr_watchdog_reset

//--- test/wdr_watchdog_reset_checker.sv
module wdr_watchdog_reset_checker #(
   parameter int P_OSC_DIV        = 2,
   parameter int P_STARTUP_CYCLES = 4
) (
   input wire logic       I_CLK,
   input wire logic       I_NRST,
   input wire logic       I_WDR,
   input wire logic       I_IRQ_ACK,
   input wire logic       I_ALWAYS_ON_FUSE,
   input wire logic       I_BROWNOUT_ENABLE,
   input wire logic       I_BROWNOUT_LOW,
   input wire logic       O_TIMEOUT_IRQ,
   input wire logic       O_WDOG_RST_PULSE,
   input wire logic       O_CORE_RST
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_GAP = 2046 * P_OSC_DIV;
   int since_r;
   int since_nxt;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   // ==========================================================================
   // cycles since the last restart or core reset
   // ==========================================================================
   always_comb begin
      since_nxt = (I_WDR || O_CORE_RST) ? 0 : since_r + 1;
   end
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         since_r <= 0;
      end else begin
         since_r <= since_nxt;
      end
   end

   // ==========================================================================
   // properties
   // ==========================================================================
   a_pulse_single: assert property (
      O_WDOG_RST_PULSE |=> !O_WDOG_RST_PULSE) else $error("reset pulse too long");
   a_pulse_core_rst: assert property (
      O_WDOG_RST_PULSE |=> O_CORE_RST) else $error("no core reset after pulse");
   a_pulse_when_run: assert property (
      O_WDOG_RST_PULSE |-> !$past(O_CORE_RST)) else $error("pulse while core held");
   a_restart_gap: assert property (
      O_WDOG_RST_PULSE |-> since_r >= MIN_GAP) else $error("timeout too soon");
   a_fuse_no_irq: assert property (
      I_ALWAYS_ON_FUSE [*8] |-> !O_TIMEOUT_IRQ) else $error("irq with fuse set");
   a_brownout_hold: assert property (
      (I_BROWNOUT_ENABLE && I_BROWNOUT_LOW) [*7] |-> O_CORE_RST) else $error("no brown-out reset");
   a_release_delay: assert property (
      $fell(O_CORE_RST) |-> $past(O_CORE_RST, P_STARTUP_CYCLES)) else $error("delay short");
   a_ack_clears_irq: assert property (
      I_IRQ_ACK && O_TIMEOUT_IRQ |=> !O_TIMEOUT_IRQ) else $error("ack left irq");

   c_pulse: cover property (O_WDOG_RST_PULSE);
   c_irq: cover property ($rose(O_TIMEOUT_IRQ));
   c_release: cover property ($fell(O_CORE_RST));
endmodule : wdr_watchdog_reset_checker

bind wdr_watchdog_reset wdr_watchdog_reset_checker #(
   .P_OSC_DIV(P_OSC_DIV),
   .P_STARTUP_CYCLES(P_STARTUP_CYCLES)
) i_wdr_watchdog_reset_checker (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_WDR(I_WDR), .I_IRQ_ACK(I_IRQ_ACK),
   .I_ALWAYS_ON_FUSE(I_ALWAYS_ON_FUSE), .I_BROWNOUT_ENABLE(I_BROWNOUT_ENABLE),
   .I_BROWNOUT_LOW(I_BROWNOUT_LOW), .O_TIMEOUT_IRQ(O_TIMEOUT_IRQ),
   .O_WDOG_RST_PULSE(O_WDOG_RST_PULSE), .O_CORE_RST(O_CORE_RST)
);

//--- test/wdr_core_model.sv
module wdr_core_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_kick,
   input  wire logic       i_ack_en,
   input  wire logic [3:0] i_ack_dly,
   input  wire logic       i_irq,
   output logic            o_wdr,
   output logic            o_irq_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_r;
   logic [3:0] wait_nxt;
   logic       wdr_nxt;
   logic       ack_nxt;

   // restart instruction and vector entry, each a one-cycle pulse
   always_comb begin
      wdr_nxt  = i_kick;
      ack_nxt  = 1'b0;
      wait_nxt = 4'h0;
      if (i_irq && i_ack_en && !o_irq_ack) begin
         wait_nxt = wait_r + 4'h1;
         if (wait_r == i_ack_dly) begin
            ack_nxt  = 1'b1;
            wait_nxt = 4'h0;
         end
      end
   end

   // register the core's outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_r    <= 4'h0;
         o_wdr     <= 1'b0;
         o_irq_ack <= 1'b0;
      end else begin
         wait_r    <= wait_nxt;
         o_wdr     <= wdr_nxt;
         o_irq_ack <= ack_nxt;
      end
   end
endmodule : wdr_core_model

//--- test/wdr_watchdog_reset_bench.sv
module wdr_watchdog_reset_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdr_pkg::*;
   localparam int OSC   = 2;
   localparam int EXP_T = 2 * 2048 * OSC;
   logic       clk;
   logic       nrst   = 1'b0;
   logic [3:0] addr   = 4'h0;
   logic [7:0] wdata  = 8'h00;
   logic       wr     = 1'b0;
   logic       rd     = 1'b0;
   logic       fuse   = 1'b0;
   logic       bo_en  = 1'b1;
   logic [2:0] src    = 3'h0;
   logic       kick   = 1'b0;
   logic       ack_en = 1'b0;
   logic [3:0] ack_dly = 4'h0;
   logic [7:0] rdata;
   logic       wdr;
   logic       ack;
   logic       irq;
   logic       pulse;
   logic       core;
   logic [2:0] mon;
   logic [7:0] exp_c [3] = '{8'h03, 8'h07, 8'h17};
   int         error_cnt = 0;
   int         n_checks  = 0;
   int         n;
   logic       seen;

   assign mon = {core, irq, pulse};

   // ==========================================================================
   // design and core model
   // ==========================================================================
   wdr_watchdog_reset #(.P_OSC_DIV(OSC), .P_STARTUP_CYCLES(4)) i_wdr_watchdog_reset (
      .I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
      .O_RDATA(rdata), .I_WDR(wdr), .I_IRQ_ACK(ack), .I_ALWAYS_ON_FUSE(fuse),
      .I_BROWNOUT_ENABLE(bo_en), .I_BROWNOUT_LOW(src[1]), .I_PIN_RST_N(~src[0]), .I_JTAG_RST(src[2]),
      .O_TIMEOUT_IRQ(irq), .O_WDOG_RST_PULSE(pulse), .O_CORE_RST(core));
   wdr_core_model i_wdr_core_model (
      .i_clk(clk), .i_rst_n(nrst), .i_kick(kick), .i_ack_en(ack_en),
      .i_ack_dly(ack_dly), .i_irq(irq), .o_wdr(wdr), .o_irq_ack(ack));

   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ==========================================================================
   // tasks
   // ==========================================================================
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
      @(posedge clk);
   endtask : rd_chk

   // bounded wait for one monitored output to reach a level; looked at mid-cycle, returns on a rising edge
   task automatic wait_on(input int idx, input logic lvl, input int lim);
      n = 0;
      @(negedge clk);
      while (mon[idx] !== lvl) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            error_cnt++;
            stop_test();
         end
      end
      @(posedge clk);
   endtask : wait_on

   task automatic restart;
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
   endtask : restart

   // clear the cause flags, then turn the watchdog off through the timed sequence
   task automatic disarm;
      wr_reg(ADDR_CAUSE, 8'h00);
      wr_reg(ADDR_WDCTL, 8'h18);
      wr_reg(ADDR_WDCTL, 8'h00);
   endtask : disarm

   // ==========================================================================
   // main sequence
   // ==========================================================================
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      wait_on(2, 1'b0, 20);
      rd_chk(ADDR_CAUSE, 8'h01);
      rd_chk(ADDR_WDCTL, 8'h00);
      rd_chk(4'h7, 8'h00);
      // pin, brown-out and debug resets; flags accumulate
      for (int k = 0; k < 3; k++) begin
         src <= 3'h1 << k;
         repeat (10) @(posedge clk);
         check(core, 1'b1);
         src <= 3'h0;
         wait_on(2, 1'b0, 40);
         rd_chk(ADDR_CAUSE, exp_c[k]);
      end
      wr_reg(ADDR_CAUSE, 8'h00);
      rd_chk(ADDR_CAUSE, 8'h00);
      // a low supply is ignored while the detector is off
      bo_en <= 1'b0;
      src   <= 3'h2;
      repeat (10) @(posedge clk);
      check(core, 1'b0);
      src   <= 3'h0;
      bo_en <= 1'b1;
      rd_chk(ADDR_CAUSE, 8'h00);
      // protected fields outside and inside the window
      wr_reg(ADDR_WDCTL, 8'h07);
      rd_chk(ADDR_WDCTL, 8'h00);
      wr_reg(ADDR_WDCTL, 8'h08);
      wr_reg(ADDR_WDCTL, 8'h00);
      rd_chk(ADDR_WDCTL, 8'h08);
      wr_reg(ADDR_WDCTL, 8'h18);
      rd_chk(ADDR_WDCTL, 8'h18);
      rd_chk(ADDR_WDCTL, 8'h18);
      rd_chk(ADDR_WDCTL, 8'h08);
      wr_reg(ADDR_WDCTL, 8'h18);
      wr_reg(ADDR_WDCTL, 8'h00);
      rd_chk(ADDR_WDCTL, 8'h00);
      wr_reg(ADDR_WDCTL, 8'h08);
      wr_reg(ADDR_WDCTL, 8'h18);
      repeat (4) @(posedge clk);
      wr_reg(ADDR_WDCTL, 8'h01);
      rd_chk(ADDR_WDCTL, 8'h08);
      // reset mode, second shortest period
      restart();
      wr_reg(ADDR_WDCTL, 8'h18);
      wr_reg(ADDR_WDCTL, 8'h09);
      rd_chk(ADDR_WDCTL, 8'h09);
      seen = 1'b0;
      repeat (3) begin
         restart();
         repeat (3000) begin
            @(posedge clk);
            seen = seen | pulse;
         end
      end
      check(seen, 1'b0);
      restart();
      wait_on(0, 1'b1, EXP_T + 40);
      check(n > EXP_T - 12 && n < EXP_T + 12, 1'b1);
      wait_on(2, 1'b0, 40);
      rd_chk(ADDR_CAUSE, 8'h08);
      rd_chk(ADDR_WDCTL, 8'h08);
      wr_reg(ADDR_WDCTL, 8'h18);
      wr_reg(ADDR_WDCTL, 8'h00);
      rd_chk(ADDR_WDCTL, 8'h08);
      disarm();
      rd_chk(ADDR_WDCTL, 8'h00);
      // interrupt mode
      wr_reg(ADDR_WDCTL, 8'h40);
      restart();
      wait_on(1, 1'b1, 4300);
      rd_chk(ADDR_CAUSE, 8'h00);
      rd_chk(ADDR_WDCTL, 8'hC0);
      ack_dly <= 4'h2;
      ack_en  <= 1'b1;
      wait_on(1, 1'b0, 20);
      ack_en <= 1'b0;
      rd_chk(ADDR_WDCTL, 8'h40);
      // combined mode, slow vector entry
      restart();
      wr_reg(ADDR_WDCTL, 8'h48);
      wait_on(1, 1'b1, 4300);
      rd_chk(ADDR_WDCTL, 8'hC8);
      ack_dly <= 4'h9;
      ack_en  <= 1'b1;
      wait_on(1, 1'b0, 30);
      ack_en <= 1'b0;
      rd_chk(ADDR_WDCTL, 8'h08);
      wait_on(0, 1'b1, 4300);
      check(irq, 1'b0);
      wait_on(2, 1'b0, 40);
      rd_chk(ADDR_CAUSE, 8'h08);
      disarm();
      // combined mode, vector never entered: the next expiry resets
      wr_reg(ADDR_WDCTL, 8'h48);
      restart();
      wait_on(1, 1'b1, 4300);
      wait_on(0, 1'b1, 4300);
      check(irq, 1'b1);
      wait_on(2, 1'b0, 40);
      rd_chk(ADDR_CAUSE, 8'h08);
      disarm();
      // always-on fuse
      fuse <= 1'b1;
      repeat (8) @(posedge clk);
      wr_reg(ADDR_WDCTL, 8'h40);
      rd_chk(ADDR_WDCTL, 8'h08);
      check(irq, 1'b0);
      stop_test();
   end
endmodule : wdr_watchdog_reset_bench
